// >>> timer16_irq_pkg.sv
// Purpose: Shared constants for the 16-bit timer capture and flag block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Printed offsets are indexes; byte address is four times index
package timer16_irq_pkg;
    // ------------------------------------------------------------------
    // Register indexes (byte address is four times index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_FLAGS = 8'h36;
    localparam logic [7:0] IDX_MASK = 8'h37;
    localparam logic [7:0] IDX_FLAGS_EXT = 8'h7C;
    localparam logic [7:0] IDX_MASK_EXT = 8'h7D;
    localparam logic [7:0] IDX_CTRL = 8'h40;
    localparam logic [7:0] IDX_CAP1 = 8'h41;
    localparam logic [7:0] IDX_CAP3 = 8'h42;
    localparam logic [7:0] IDX_TEMP = 8'h43;
    localparam logic [7:0] IDX_IRQ = 8'h44;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_CAP = 5;
    localparam int BIT_MA = 4;
    localparam int BIT_MB = 3;
    localparam int BIT_WRAP = 2;
    localparam int BIT_MC = 1;
    localparam int BIT_T1MC = 0;
    localparam int CTRL_LEGACY = 0;
    localparam int CTRL_ACSEL = 1;
    localparam int CTRL_GIE = 2;
    localparam int CTRL_T1MODE = 4;
    localparam int CTRL_T3MODE = 8;
    localparam logic [7:0] T1_MASK_BITS = 8'h3C;
    localparam logic [7:0] EXT_MASK_BITS = 8'h3F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_CTRL = 16'h0000;
    // ------------------------------------------------------------------
    // Waveform modes
    // ------------------------------------------------------------------
    localparam logic [3:0] WAVE_NORMAL = 4'h0;
    localparam logic [3:0] WAVE_CLR_MATCH = 4'h4;
    localparam logic [3:0] WAVE_CLR_CAPTOP = 4'hC;
    localparam logic [3:0] WAVE_FAST_CAPTOP = 4'hE;
    localparam logic [3:0] WAVE_PC_CAPTOP = 4'h8;
    localparam logic [3:0] WAVE_PFC_CAPTOP = 4'hA;
    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b00,
        BUS_DATA = 2'b01
    } bus_state_type;
endpackage

// >>> timer16_capture.sv
// Purpose: One 16-bit capture channel with capture-as-TOP support
// Assumes: Capture strobe is a one-cycle synchronous pulse
// Notes: Capture register is also the TOP source in capture-top modes
`timescale 1ns/1ps
`default_nettype none
module timer16_capture
    import timer16_irq_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic capture_strobe,
    input wire logic [WIDTH-1:0] counter_value,
    input wire logic [3:0] waveform_mode_select,
    output logic [WIDTH-1:0] capture_value,
    output logic top_is_capture,
    output logic capture_event
);
    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // capture as TOP
    always_comb
    begin
        case (waveform_mode_select)
            WAVE_CLR_CAPTOP, WAVE_FAST_CAPTOP,
            WAVE_PC_CAPTOP, WAVE_PFC_CAPTOP: top_is_capture = 1'b1;
            default: top_is_capture = 1'b0;
        endcase
    end
    always_comb
    begin
        if (top_is_capture)
        begin
            capture_event = (counter_value == capture_value);
        end
        else
        begin
            capture_event = capture_strobe;
        end
    end
    // ------------------------------------------------------------------
    // Capture register
    // ------------------------------------------------------------------
    // latch counter value
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            capture_value <= '0;
        end
        else if (capture_strobe && !top_is_capture)
        begin
            capture_value <= counter_value;
        end
    end
    chk_capture_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        capture_strobe && !top_is_capture |=>
        capture_value == $past(counter_value))
        else $error("capture register missed counter value");
endmodule
`default_nettype wire

// >>> timer16_flag_bank.sv
// Purpose: Sticky event flags with write-one clear and vector clear
// Assumes: Set, clear and acknowledge are synchronous
// Notes: A hardware set beats a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module timer16_flag_bank
#(
    parameter int N = 6
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [N-1:0] set_in,
    input wire logic [N-1:0] w1c_in,
    input wire logic [N-1:0] ack_in,
    output logic [N-1:0] flag_reg
);
    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    for (genvar i = 0; i < N; i++)
    begin : g_flag
        always_ff @(posedge clk_sys or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                flag_reg[i] <= 1'b0;
            end
            else if (set_in[i])
            begin
                flag_reg[i] <= 1'b1;
            end
            else if (w1c_in[i] || ack_in[i])
            begin
                flag_reg[i] <= 1'b0;
            end
        end
    end
    chk_set_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
        |set_in |=> (flag_reg & $past(set_in)) == $past(set_in))
        else $error("flag set was lost");
    chk_w1c_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 ($past(w1c_in) != '0) && ($past(set_in) == '0) |->
        (flag_reg & $past(w1c_in)) == '0)
        else $error("write one did not clear flag");
endmodule
`default_nettype wire

// >>> timer16_capture_irq_flags.sv
// Purpose: Capture registers and interrupt flags for timers 1 and 3
// Assumes: AHB-Lite slave, single word transfers, one clock domain
// Notes: Counters and compare values come from outside; waveform modes come from the control register
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_irq_flags
    import timer16_irq_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [WIDTH-1:0] t1_counter_value,
    input wire logic [WIDTH-1:0] t3_counter_value,
    input wire logic [WIDTH-1:0] t1_compare_a,
    input wire logic [WIDTH-1:0] t1_compare_b,
    input wire logic [WIDTH-1:0] t1_compare_c,
    input wire logic [WIDTH-1:0] t3_compare_a,
    input wire logic [WIDTH-1:0] t3_compare_b,
    input wire logic [WIDTH-1:0] t3_compare_c,
    input wire logic t1_capture_input_pin,
    input wire logic t3_capture_input_pin,
    input wire logic comparator_out,
    input wire logic t1_wrap,
    input wire logic t3_wrap,
    input wire logic t1_mode_wrap,
    input wire logic t3_mode_wrap,
    input wire logic forced_match_strobe,
    input wire logic [5:0] ack_main,
    input wire logic [5:0] ack_ext,
    output logic [5:0] req_main,
    output logic [5:0] req_ext,
    output logic [WIDTH-1:0] t1_top_value,
    output logic [WIDTH-1:0] t3_top_value,
    output logic t1_top_valid,
    output logic t3_top_valid,
    output logic irq
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    bus_state_type bus_reg;
    logic [7:0] idx_reg;
    logic wr_reg;
    logic [7:0] mask_reg;
    logic [7:0] mask_ext_reg;
    logic [15:0] ctrl_reg;
    logic [7:0] temp_reg;
    logic [WIDTH-1:0] cap1_value;
    logic [WIDTH-1:0] cap3_value;
    logic cap1_top;
    logic cap3_top;
    logic cap1_event;
    logic cap3_event;
    logic t1_strobe;
    logic [5:0] flags_main;
    logic [5:0] flags_ext;
    logic [5:0] set_main;
    logic [5:0] set_ext;
    logic [5:0] w1c_main;
    logic [5:0] w1c_ext;
    logic [5:0] ack_ext_gated;
    logic [5:0] match_next;
    logic [5:0] match_reg;
    logic [5:0] req_main_next;
    logic [5:0] req_ext_next;
    logic legacy;
    logic gie;
    logic wr_now;
    logic rd_now;
    logic [31:0] rd_next;
    logic [7:0] wbyte;
    assign legacy = ctrl_reg[CTRL_LEGACY];
    assign gie = ctrl_reg[CTRL_GIE];
    assign wbyte = hwdata[7:0];
    // ------------------------------------------------------------------
    // Capture channels
    // ------------------------------------------------------------------
    // comparator as timer 1 source
    assign t1_strobe = ctrl_reg[CTRL_ACSEL] ? comparator_out
        : t1_capture_input_pin;
    timer16_capture #(.WIDTH(WIDTH)) u_cap1
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .capture_strobe(t1_strobe),
        .counter_value(t1_counter_value),
        .waveform_mode_select(ctrl_reg[CTRL_T1MODE +: 4]),
        .capture_value(cap1_value),
        .top_is_capture(cap1_top),
        .capture_event(cap1_event)
    );
    timer16_capture #(.WIDTH(WIDTH)) u_cap3
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .capture_strobe(t3_capture_input_pin),
        .counter_value(t3_counter_value),
        .waveform_mode_select(ctrl_reg[CTRL_T3MODE +: 4]),
        .capture_value(cap3_value),
        .top_is_capture(cap3_top),
        .capture_event(cap3_event)
    );
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            t1_top_value <= '0;
            t3_top_value <= '0;
            t1_top_valid <= 1'b0;
            t3_top_valid <= 1'b0;
        end
        else
        begin
            t1_top_value <= cap1_value;
            t3_top_value <= cap3_value;
            t1_top_valid <= cap1_top;
            t3_top_valid <= cap3_top;
        end
    end
    // ------------------------------------------------------------------
    // Compare matches, one cycle late
    // ------------------------------------------------------------------
    // forced strobe excluded
    always_comb
    begin
        match_next = 6'h00;
        match_next[BIT_MA] = t3_counter_value == t3_compare_a;
        match_next[BIT_MB] = t3_counter_value == t3_compare_b;
        match_next[BIT_MC] = t3_counter_value == t3_compare_c;
        match_next[BIT_T1MC] = t1_counter_value == t1_compare_c;
        match_next[BIT_CAP] = t1_counter_value == t1_compare_a;
        match_next[BIT_WRAP] = t1_counter_value == t1_compare_b;
    end
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            match_reg <= 6'h00;
        end
        else
        begin
            match_reg <= match_next;
        end
    end
    // ------------------------------------------------------------------
    // Flag sources
    // ------------------------------------------------------------------
    // timer 1 flag layout
    always_comb
    begin
        set_main = 6'h00;
        set_main[BIT_CAP - 2] = cap1_event;
        set_main[BIT_MA - 2] = match_reg[BIT_CAP];
        set_main[BIT_MB - 2] = match_reg[BIT_WRAP];
        set_main[BIT_WRAP - 2] = t1_mode_wrap ? t1_wrap
            : (t1_counter_value == cap1_value && cap1_top);
    end
    always_comb
    begin
        set_ext = 6'h00;
        set_ext[BIT_CAP] = cap3_event;
        set_ext[BIT_MA] = match_reg[BIT_MA];
        set_ext[BIT_MB] = match_reg[BIT_MB];
        set_ext[BIT_WRAP] = t3_mode_wrap ? t3_wrap
            : (t3_counter_value == cap3_value && cap3_top);
        set_ext[BIT_MC] = match_reg[BIT_MC];
        set_ext[BIT_T1MC] = match_reg[BIT_T1MC];
    end
    assign w1c_main = (wr_now && idx_reg == IDX_FLAGS)
        ? wbyte[7:2] & T1_MASK_BITS[7:2] : 6'h00;
    assign w1c_ext = (wr_now && idx_reg == IDX_FLAGS_EXT && !legacy)
        ? wbyte[5:0] : 6'h00;
    assign ack_ext_gated = legacy ? 6'h00 : ack_ext;
    timer16_flag_bank #(.N(6)) u_flags_main
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .set_in(set_main),
        .w1c_in(w1c_main),
        .ack_in(ack_main & T1_MASK_BITS[7:2]),
        .flag_reg(flags_main)
    );
    timer16_flag_bank #(.N(6)) u_flags_ext
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .set_in(set_ext),
        .w1c_in(w1c_ext),
        .ack_in(ack_ext_gated),
        .flag_reg(flags_ext)
    );
    // ------------------------------------------------------------------
    // Requests and interrupt
    // ------------------------------------------------------------------
    // enable, global and flag
    assign req_main_next = gie ? flags_main & mask_reg[7:2] : 6'h00;
    assign req_ext_next = (gie && !legacy)
        ? flags_ext & mask_ext_reg[5:0] : 6'h00;
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_main <= 6'h00;
            req_ext <= 6'h00;
            irq <= 1'b0;
        end
        else
        begin
            req_main <= req_main_next;
            req_ext <= req_ext_next;
            irq <= |{req_main_next, req_ext_next};
        end
    end
    chk_req_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !gie |=> req_main == 6'h00 && req_ext == 6'h00 && !irq)
        else $error("request raised with global flag clear");
    chk_req_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> req_main == ($past(gie) ? $past(flags_main)
        & $past(mask_reg[7:2]) : 6'h00))
        else $error("request does not match flag and mask");
    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    assign wr_now = (bus_reg == BUS_DATA) && wr_reg;
    assign rd_now = hsel && hready && htrans[1] && !hwrite;
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus_reg <= BUS_IDLE;
            idx_reg <= 8'h00;
            wr_reg <= 1'b0;
        end
        else if (hready)
        begin
            bus_reg <= (hsel && htrans[1]) ? BUS_DATA : BUS_IDLE;
            idx_reg <= haddr[9:2];
            wr_reg <= hsel && htrans[1] && hwrite;
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mask_reg <= RESET_BYTE;
            mask_ext_reg <= RESET_BYTE;
            ctrl_reg <= RESET_CTRL;
        end
        else if (wr_now)
        begin
            if (idx_reg == IDX_MASK)
            begin
                mask_reg <= wbyte & T1_MASK_BITS;
            end
            if (idx_reg == IDX_MASK_EXT && !legacy)
            begin
                mask_ext_reg <= wbyte & EXT_MASK_BITS;
            end
            if (idx_reg == IDX_CTRL)
            begin
                ctrl_reg <= hwdata[15:0];
            end
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            temp_reg <= RESET_BYTE;
        end
        else if (rd_now && haddr[9:2] == IDX_CAP1)
        begin
            temp_reg <= cap1_value[15:8];
        end
        else if (rd_now && haddr[9:2] == IDX_CAP3)
        begin
            temp_reg <= cap3_value[15:8];
        end
    end
    // Read data for the next data phase
    always_comb
    begin
        rd_next = 32'h0000_0000;
        case (haddr[9:2])
            IDX_FLAGS: rd_next[7:2] = flags_main
                & T1_MASK_BITS[7:2];
            IDX_MASK: rd_next[7:0] = mask_reg;
            IDX_FLAGS_EXT: rd_next[5:0] = legacy ? 6'h00 : flags_ext;
            IDX_MASK_EXT: rd_next[7:0] = legacy ? 8'h00 : mask_ext_reg;
            IDX_CTRL: rd_next[15:0] = ctrl_reg;
            IDX_CAP1: rd_next[15:0] = cap1_value;
            IDX_CAP3: rd_next[15:0] = cap3_value;
            IDX_TEMP: rd_next[7:0] = temp_reg;
            IDX_IRQ: rd_next[11:0] = {req_ext, req_main};
            default: rd_next = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_now)
            begin
                hrdata <= rd_next;
            end
        end
    end
    chk_legacy_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
        legacy && $stable(legacy) |=> $stable(mask_ext_reg))
        else $error("extended mask changed in legacy mode");
    chk_match_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
        t3_counter_value == t3_compare_a ##1 1'b1 |=> flags_ext[BIT_MA])
        else $error("compare flag not set after match");
    chk_temp_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rd_now && haddr[9:2] == IDX_CAP1 |=>
        temp_reg == $past(cap1_value[15:8]))
        else $error("temporary byte not latched");
endmodule
`default_nettype wire

// >>> timer16_vector_model.sv
// Purpose: Interrupt vector unit model that takes pending requests
// Assumes: Requests are levels; one acknowledge pulse per vector
// Notes: Pauses after each vector so the request has time to drop
`timescale 1ns/1ps
`default_nettype none
module timer16_vector_model
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic vec_en,
    input wire logic [5:0] req_main,
    input wire logic [5:0] req_ext,
    output logic [5:0] ack_main,
    output logic [5:0] ack_ext
);
    logic [2:0] hold_reg;
    // ------------------------------------------------------------------
    // Vector selection
    // ------------------------------------------------------------------
    // one-cycle acknowledge per vector
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_main <= 6'h00;
            ack_ext <= 6'h00;
            hold_reg <= 3'h0;
        end
        else if (hold_reg != 3'h0)
        begin
            ack_main <= 6'h00;
            ack_ext <= 6'h00;
            hold_reg <= hold_reg - 3'h1;
        end
        else if (vec_en && (req_main != 6'h00 || req_ext != 6'h00))
        begin
            ack_main <= req_main & (~req_main + 6'h01);
            ack_ext <= (req_main != 6'h00) ? 6'h00
                : req_ext & (~req_ext + 6'h01);
            hold_reg <= 3'h4;
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the timer capture and flag block
// Assumes: Bus slave may add wait states; the bench polls hreadyout
// Notes: Counters and compare values are driven as plain levels
`timescale 1ns/1ps
`default_nettype none
module tb
    import timer16_irq_pkg::*;
;
    logic clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, wraps = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, irq, vec_en = 1'b0, fms = 1'b0;
    logic pin1 = 1'b0, pin3 = 1'b0, cmp_out = 1'b0;
    logic t1_top_valid, t3_top_valid;
    logic [15:0] t1_cnt = 16'h0, t3_cnt = 16'h0, t1_top_value, t3_top_value;
    logic [15:0] cmp [6] = '{default: 16'hFFFF};
    logic [5:0] ack_main, ack_ext, req_main, req_ext;
    logic [7:0] em [8] = '{8'h10, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h04, 8'h00};
    logic [7:0] ee [8] = '{8'h00, 8'h00, 8'h01, 8'h10, 8'h08, 8'h02,
        8'h00, 8'h04};
    int failures = 0, check_count = 0;
    assign hready = hreadyout;
    always #2 clk_sys = ~clk_sys;
    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    timer16_vector_model partner_u (.clk_sys, .sys_rst, .vec_en, .req_main,
        .req_ext, .ack_main, .ack_ext);
    timer16_capture_irq_flags dut_u (.clk_sys, .sys_rst, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
        .hresp, .t1_counter_value(t1_cnt), .t3_counter_value(t3_cnt),
        .t1_compare_a(cmp[0]), .t1_compare_b(cmp[1]), .t1_compare_c(cmp[2]),
        .t3_compare_a(cmp[3]), .t3_compare_b(cmp[4]), .t3_compare_c(cmp[5]),
        .t1_capture_input_pin(pin1), .t3_capture_input_pin(pin3),
        .comparator_out(cmp_out), .t1_wrap(wraps[0]), .t3_wrap(wraps[1]),
        .t1_mode_wrap(1'b1), .t3_mode_wrap(1'b1), .forced_match_strobe(fms),
        .ack_main, .ack_ext, .req_main, .req_ext, .t1_top_value,
        .t3_top_value, .t1_top_valid, .t3_top_valid, .irq);
    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction
    task complete_run;
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_rdy;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask
    task bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task rdchk(input logic [31:0] a, e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task pulse1(input logic [15:0] c);
        t1_cnt <= c;
        pin1 <= 1'b1;
        @(posedge clk_sys);
        pin1 <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        rdchk(ba(IDX_FLAGS), 32'h0);
        rdchk(ba(IDX_MASK), 32'h0);
        rdchk(ba(IDX_FLAGS_EXT), 32'h0);
        rdchk(ba(IDX_MASK_EXT), 32'h0);
        rdchk(32'h0000_0300, 32'h0);
    endtask
    task t_capture;
        pulse1(16'hA5C3);
        rdchk(ba(IDX_CAP1), 32'h0000_A5C3);
        rdchk(ba(IDX_TEMP), 32'h0000_00A5);
        rdchk(ba(IDX_FLAGS), 32'h20);
        wr(ba(IDX_FLAGS), 32'h0);
        rdchk(ba(IDX_FLAGS), 32'h20);
        wr(ba(IDX_FLAGS), 32'h20);
        rdchk(ba(IDX_FLAGS), 32'h0);
        wr(ba(IDX_CTRL), 32'h2);
        t1_cnt <= 16'h0F0E;
        t3_cnt <= 16'h7E81;
        cmp_out <= 1'b1;
        pin3 <= 1'b1;
        @(posedge clk_sys);
        cmp_out <= 1'b0;
        pin3 <= 1'b0;
        t1_cnt <= 16'h0;
        repeat (3) @(posedge clk_sys);
        rdchk(ba(IDX_CAP1), 32'h0000_0F0E);
        rdchk(ba(IDX_CAP3), 32'h0000_7E81);
        rdchk(ba(IDX_FLAGS_EXT), 32'h20);
        wr(ba(IDX_FLAGS_EXT), 32'h20);
        wr(ba(IDX_FLAGS), 32'h20);
        wr(ba(IDX_CTRL), 32'hC0);
        repeat (2) @(posedge clk_sys);
        chk({15'h0, t1_top_valid, t1_top_value}, 32'h0001_0F0E);
        chk({15'h0, t3_top_valid, t3_top_value}, 32'h0000_7E81);
        pulse1(16'h0F0E);
        t1_cnt <= 16'h0;
        rdchk(ba(IDX_FLAGS), 32'h20);
        wr(ba(IDX_FLAGS), 32'h20);
        wr(ba(IDX_CTRL), 32'h0);
    endtask
    task t_match;
        int i;
        t1_cnt <= 16'h0100;
        t3_cnt <= 16'h0100;
        for (i = 0; i < 8; i++)
        begin
            if (i < 6)
                cmp[i] <= 16'h0100;
            else
                wraps[i-6] <= 1'b1;
            @(posedge clk_sys);
            cmp <= '{default: 16'hFFFF};
            wraps <= 2'b00;
            repeat (3) @(posedge clk_sys);
            rdchk(ba(IDX_FLAGS), {24'h0, em[i]});
            rdchk(ba(IDX_FLAGS_EXT), {24'h0, ee[i]});
            wr(ba(IDX_FLAGS), 32'h3C);
            wr(ba(IDX_FLAGS_EXT), 32'h3F);
        end
        fms <= 1'b1;
        @(posedge clk_sys);
        fms <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rdchk(ba(IDX_FLAGS), 32'h0);
    endtask
    task t_irq;
        pulse1(16'h0042);
        wr(ba(IDX_MASK), 32'h20);
        rdchk(ba(IDX_MASK), 32'h20);
        repeat (3) @(posedge clk_sys);
        chk({25'h0, irq, req_main}, 32'h0);
        wr(ba(IDX_CTRL), 32'h4);
        repeat (3) @(posedge clk_sys);
        chk({25'h0, irq, req_main}, 32'h48);
        wr(ba(IDX_MASK), 32'h0);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(ba(IDX_MASK), 32'h20);
        wr(ba(IDX_FLAGS), 32'h20);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        vec_en <= 1'b1;
        pulse1(16'h0043);
        repeat (8) @(posedge clk_sys);
        rdchk(ba(IDX_FLAGS), 32'h0);
        vec_en <= 1'b0;
    endtask
    task t_legacy;
        wr(ba(IDX_CTRL), 32'h1);
        wr(ba(IDX_MASK_EXT), 32'h3F);
        rdchk(ba(IDX_MASK_EXT), 32'h0);
        wr(ba(IDX_CTRL), 32'h4);
        wr(ba(IDX_MASK_EXT), 32'h3F);
        rdchk(ba(IDX_MASK_EXT), 32'h3F);
        pin3 <= 1'b1;
        @(posedge clk_sys);
        pin3 <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({25'h0, irq, req_ext}, 32'h60);
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_capture();
        t_match();
        t_irq();
        t_legacy();
        complete_run();
    end
    initial
    begin
        #200000;
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
